// ### bench/pesl_link_model.sv
// Link partner: raises one error message per request and scrambles the ID when idle.
// Assumes requests change just after the rising clock edge.
module pesl_link_model
	import pesl_pkg::*;
(
	// Request from the bench
	input wire logic clk_sys,
	input wire logic [1:0] cls,
	input wire logic [15:0] id,
	// Message toward the design
	output pesl_err_t link_err
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] junk_r = 16'hA5C3;
	// Idle ID bits keep moving so a stale ID can never pass for a capture
	always_ff @(posedge clk_sys) begin
		junk_r <= ~junk_r ^ id;
	end
	assign link_err = (cls != 2'h0) ? {1'b1, cls == 2'h1, cls == 2'h2, cls == 2'h3, id} : {4'h0, junk_r};
endmodule : pesl_link_model

// ### bench/tb.sv
// Self-checking bench for the error source log, compared with a reference model at every result.
// Assumes the link model drives link_err and the bench drives all other inputs.
module tb import pesl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, sys_rst = 1'b1, pwr_on_rst = 1'b1, pq_ovf_report_mask_n = 1'b1;
	logic first_unc_flag = 1'b0, first_cor_flag = 1'b0;
	logic [1:0] cls = 2'h0, pq_hdr_ovf = 2'h0, pq_data_ovf = 2'h0;
	logic [15:0] id = 16'h0000;
	logic [3:0] hot_plug_err = 4'h0;
	pesl_err_t link_err;
	pesl_err_t int_err = '0;
	pesl_cfg_req_t cfg_req = '0;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid, rx_overflow_evt, unit_err_ptr_evt, sel_fatal, sel_nonfatal, sel_correctable;
	int n_mismatch = 0, checks_done = 0, seed = 59374, m_unc = 0, m_cor = 0, m_unit = 0;
	always #10 clk_sys = ~clk_sys;
	pesl_top #(.NUM_PQ(2)) u_pesl_top (.clk_sys, .sys_rst, .pwr_on_rst, .link_err, .int_err, .pq_hdr_ovf,
		.pq_data_ovf, .hot_plug_err, .pq_ovf_report_mask_n, .first_unc_flag, .first_cor_flag, .cfg_req,
		.cfg_rdata, .cfg_rvalid, .rx_overflow_evt, .unit_err_ptr_evt, .sel_fatal, .sel_nonfatal, .sel_correctable);
	pesl_link_model u_pesl_link_model (.clk_sys, .cls, .id, .link_err);
	task automatic print_verdict;
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One operation: drive at one edge, sampled at the next, results checked half a cycle later
	task automatic cyc(input logic [1:0] c, input pesl_err_t ie, input logic [1:0] ho, input logic [1:0] dv,
		input logic [3:0] p, input logic [1:0] fl, input pesl_cfg_req_t r);
		logic [15:0] lid;
		logic mk;
		logic [31:0] rx;
		lid = $random(seed);
		mk = $random(seed);
		rx = r.addr == 12'h134 ? {m_unc[15:0], m_cor[15:0]} : r.addr == 12'h140 ? m_unit : 0;
		if (!fl[1] && (c == 2'h1 || c == 2'h2 || (ie.valid && (ie.fatal || ie.nonfatal))))
			m_unc = (c == 2'h1 || c == 2'h2) ? lid : ie.req_id;
		if (!fl[0] && (c == 2'h3 || (ie.valid && ie.correctable)))
			m_cor = (c == 2'h3) ? lid : ie.req_id;
		if (r.wr && r.addr == 12'h140) m_unit = m_unit & ~{16'h0000, r.wdata[15:0]};
		m_unit = m_unit | {16'h0000, |{ho, dv}, 11'h000, p};
		@(posedge clk_sys);
		{cls, id, int_err, pq_hdr_ovf, pq_data_ovf, hot_plug_err} <= {c, lid, ie, ho, dv, p};
		{first_unc_flag, first_cor_flag, pq_ovf_report_mask_n, cfg_req} <= {fl, mk, r};
		@(posedge clk_sys);
		{cls, int_err, pq_hdr_ovf, pq_data_ovf, hot_plug_err, cfg_req} <= '0;
		@(negedge clk_sys);
		chk({cfg_rvalid, cfg_rdata}, {r.rd, r.rd ? rx : 32'h0});
		chk({rx_overflow_evt, unit_err_ptr_evt, sel_fatal, sel_nonfatal, sel_correctable},
			{|{ho, dv}, |{ho, dv} & ~mk, 2'b00, |p});
	endtask : cyc
	function automatic pesl_cfg_req_t rq(input logic w, input logic [11:0] a, input logic [31:0] d);
		return {~w, w, a, d};
	endfunction : rq
	initial begin
		repeat (12) @(posedge clk_sys);
		{sys_rst, pwr_on_rst} <= 2'b00;
		for (int i = 0; i < 240; i++) begin
			// Overflow held off in four of every 16 operations lets the W1C clear be seen as well as the set
			cyc($random(seed), $random(seed), i[2] ? $random(seed) : 0, i[3] ? $random(seed) : 0,
				i[1] ? $random(seed) : 0, $random(seed), rq(i > 2 && i[0], i % 3 == 0 ? 12'h134 :
				i % 3 == 1 ? 12'h140 : 12'h138, $random(seed)));
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			{pwr_on_rst, sys_rst} <= k ? 2'b10 : 2'b01;
			repeat (2) @(posedge clk_sys);
			{pwr_on_rst, sys_rst} <= 2'b00;
			if (k) {m_unc, m_cor, m_unit} = '0;
			cyc(0, '0, 0, 0, 0, 2'b00, rq(0, 12'h134, 0));
			cyc(0, '0, 0, 0, 0, 2'b00, rq(0, 12'h140, 0));
		end
		print_verdict();
	end
	initial begin
		#100us;
		n_mismatch++;
		print_verdict();
	end
endmodule : tb

// ### rtl/pesl_cfg.svh
// Offsets, field positions and reset values for the error source log block.
// Assumes inclusion by bare name from the top module.
`ifndef PESL_CFG_SVH
`define PESL_CFG_SVH
`define PESL_OFS_SRC_ID 12'h134
`define PESL_OFS_UNIT_ERR 12'h140
`define PESL_SRC_ID_RST 32'h00000000
`define PESL_UNIT_ERR_RST 16'h0000
`define PESL_UNC_MSB 31
`define PESL_UNC_LSB 16
`define PESL_COR_MSB 15
`define PESL_COR_LSB 0
`define PESL_PQ_OVF_BIT 15
`define PESL_HP_MSB 3
`define PESL_ERR_MSB 15
`endif

// ### rtl/pesl_pkg.sv
// Types shared by the error source log block.
// Assumes configuration accesses arrive as single-cycle strobes.
package pesl_pkg;
	typedef struct packed {
		logic valid;
		logic fatal;
		logic nonfatal;
		logic correctable;
		logic [15:0] req_id;
	} pesl_err_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pesl_cfg_req_t;
endpackage : pesl_pkg

// ### rtl/pesl_top.sv
// Error source ID capture and unit error status for a PCI Express root port.
// Assumes configuration accesses are one-cycle strobes synchronous to clk_sys,
// and a power-on reset separate from the ordinary sys_rst.
`include "pesl_cfg.svh"

module pesl_top
	import pesl_pkg::*;
#(
	parameter int NUM_PQ = 2
) (
	// Clock and resets
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic pwr_on_rst,
	// Error sources
	input wire pesl_err_t link_err,
	input wire pesl_err_t int_err,
	input wire logic [NUM_PQ-1:0] pq_hdr_ovf,
	input wire logic [NUM_PQ-1:0] pq_data_ovf,
	input wire logic [3:0] hot_plug_err,
	input wire logic pq_ovf_report_mask_n,
	// First-error flags from root error message status
	input wire logic first_unc_flag,
	input wire logic first_cor_flag,
	// Configuration access
	input wire pesl_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// Reporting
	output logic rx_overflow_evt,
	output logic unit_err_ptr_evt,
	output logic sel_fatal,
	output logic sel_nonfatal,
	output logic sel_correctable
);
	logic [31:0] src_id_r;
	logic [`PESL_ERR_MSB:0] unit_err_r;
	logic [`PESL_ERR_MSB:0] unit_err_nxt;
	logic [15:0] unc_id;
	logic [15:0] cor_id;
	logic unc_hit;
	logic cor_hit;
	logic pq_ovf;
	logic wr_unit;
	logic [31:0] rdata_nxt;

	// Link-received message wins over an internal detection in the same clock
	always_comb begin
		unc_hit = 1'b0;
		cor_hit = 1'b0;
		unc_id = link_err.req_id;
		cor_id = link_err.req_id;
		if (link_err.valid && (link_err.fatal || link_err.nonfatal)) begin
			unc_hit = 1'b1;
		end else if (int_err.valid && (int_err.fatal || int_err.nonfatal)) begin
			unc_hit = 1'b1;
			unc_id = int_err.req_id;
		end
		if (link_err.valid && link_err.correctable) begin
			cor_hit = 1'b1;
		end else if (int_err.valid && int_err.correctable) begin
			cor_hit = 1'b1;
			cor_id = int_err.req_id;
		end
	end

	// Sticky storage: only power-on reset clears it, sys_rst does not
	always_ff @(posedge clk_sys) begin
		if (pwr_on_rst) begin
			src_id_r <= `PESL_SRC_ID_RST;
		end else begin
			if (unc_hit && !first_unc_flag) begin
				src_id_r[`PESL_UNC_MSB:`PESL_UNC_LSB] <= unc_id;
			end
			if (cor_hit && !first_cor_flag) begin
				src_id_r[`PESL_COR_MSB:`PESL_COR_LSB] <= cor_id;
			end
		end
	end

	assign pq_ovf = |{pq_hdr_ovf, pq_data_ovf};
	assign wr_unit = cfg_req.wr && (cfg_req.addr == `PESL_OFS_UNIT_ERR);

	// Set wins over a simultaneous write-one clear
	always_comb begin
		unit_err_nxt = unit_err_r;
		if (wr_unit) begin
			unit_err_nxt = unit_err_r & ~cfg_req.wdata[`PESL_ERR_MSB:0];
		end
		unit_err_nxt[`PESL_HP_MSB:0] = unit_err_nxt[`PESL_HP_MSB:0] | hot_plug_err;
		if (pq_ovf) begin
			unit_err_nxt[`PESL_PQ_OVF_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (pwr_on_rst) begin
			unit_err_r <= `PESL_UNIT_ERR_RST;
		end else begin
			unit_err_r <= unit_err_nxt;
		end
	end

	// Hot-plug bits are correctable; overflow stays off every select and log
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_fatal <= 1'b0;
			sel_nonfatal <= 1'b0;
			sel_correctable <= 1'b0;
			rx_overflow_evt <= 1'b0;
			unit_err_ptr_evt <= 1'b0;
		end else begin
			sel_fatal <= 1'b0;
			sel_nonfatal <= 1'b0;
			sel_correctable <= |hot_plug_err;
			rx_overflow_evt <= pq_ovf;
			unit_err_ptr_evt <= pq_ovf && !pq_ovf_report_mask_n;
		end
	end

	// Reads
	always_comb begin
		rdata_nxt = 32'h00000000;
		if (cfg_req.addr == `PESL_OFS_SRC_ID) begin
			rdata_nxt = src_id_r;
		end else if (cfg_req.addr == `PESL_OFS_UNIT_ERR) begin
			rdata_nxt = {16'h0000, unit_err_r};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cfg_rdata <= 32'h00000000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_req.rd;
			cfg_rdata <= cfg_req.rd ? rdata_nxt : 32'h00000000;
		end
	end

	unc_capture_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(link_err.valid && link_err.fatal && !first_unc_flag) |=> (src_id_r[31:16] == $past(link_err.req_id)))
		else $error("uncorrectable id not captured");
	cor_capture_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(link_err.valid && link_err.correctable && !first_cor_flag) |=> (src_id_r[15:0] == $past(link_err.req_id)))
		else $error("correctable id not captured");
	link_prio_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(link_err.valid && link_err.nonfatal && int_err.valid && int_err.nonfatal && !first_unc_flag)
		|=> (src_id_r[31:16] != $past(int_err.req_id) || $past(int_err.req_id) == $past(link_err.req_id)))
		else $error("internal id beat link id");
	unc_hold_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		first_unc_flag |=> $stable(src_id_r[31:16]))
		else $error("uncorrectable id changed while flag set");
	sticky_ids_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(sys_rst && !unc_hit && !cor_hit) |=> $stable(src_id_r))
		else $error("source ids lost on reset");
	ovf_set_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		pq_ovf |=> unit_err_r[15])
		else $error("overflow bit not set");
	w1c_clear_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(wr_unit && cfg_req.wdata[15] && !pq_ovf) |=> !unit_err_r[15])
		else $error("overflow bit not cleared");
	w0_keep_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(unit_err_r[15] && !(wr_unit && cfg_req.wdata[15])) |=> unit_err_r[15])
		else $error("overflow bit lost");
	rx_fold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pq_ovf |=> rx_overflow_evt)
		else $error("receiver overflow not raised");
	no_escal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pq_ovf && hot_plug_err == 4'h0) |=> !sel_fatal && !sel_nonfatal && !sel_correctable)
		else $error("overflow escalated");
	ptr_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		unit_err_ptr_evt |-> $past(pq_ovf) && !$past(pq_ovf_report_mask_n))
		else $error("pointer event without masked overflow");
	rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cfg_rvalid |-> cfg_rdata[31:16] == 16'h0000 || $past(cfg_req.addr) != `PESL_OFS_UNIT_ERR)
		else $error("reserved bits not zero");

	// Capture, priority and hold of the source fields
	unc_int_cap_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(!(link_err.valid && (link_err.fatal || link_err.nonfatal)) && int_err.valid && int_err.fatal && !first_unc_flag)
		|=> (src_id_r[31:16] == $past(int_err.req_id))) else $error("internal uncorrectable id not captured");

	unc_nonfatal_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(link_err.valid && link_err.nonfatal && !first_unc_flag) |=> (src_id_r[31:16] == $past(link_err.req_id)))
		else $error("nonfatal id not captured");

	cor_int_cap_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(!(link_err.valid && link_err.correctable) && int_err.valid && int_err.correctable && !first_cor_flag)
		|=> (src_id_r[15:0] == $past(int_err.req_id))) else $error("internal correctable id not captured");

	cor_hold_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		first_cor_flag |=> $stable(src_id_r[15:0]))
		else $error("correctable id changed while flag set");

	unc_idle_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(!(link_err.valid && (link_err.fatal || link_err.nonfatal)) && !(int_err.valid && (int_err.fatal || int_err.nonfatal)))
		|=> $stable(src_id_r[31:16])) else $error("uncorrectable id changed without error");

	cor_idle_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(!(link_err.valid && link_err.correctable) && !(int_err.valid && int_err.correctable))
		|=> $stable(src_id_r[15:0])) else $error("correctable id changed without error");

	prio_unc_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(link_err.valid && link_err.fatal && int_err.valid && int_err.nonfatal && !first_unc_flag)
		|=> (src_id_r[31:16] == $past(link_err.req_id))) else $error("link uncorrectable id lost priority");

	prio_cor_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(link_err.valid && link_err.correctable && int_err.valid && int_err.correctable && !first_cor_flag)
		|=> (src_id_r[15:0] == $past(link_err.req_id))) else $error("link correctable id lost priority");

	por_clear_a: assert property (@(posedge clk_sys)
		pwr_on_rst |=> (src_id_r == `PESL_SRC_ID_RST))
		else $error("source ids not cleared at power-on");

	por_unit_a: assert property (@(posedge clk_sys)
		pwr_on_rst |=> (unit_err_r == `PESL_UNIT_ERR_RST))
		else $error("unit status not cleared at power-on");

	src_ro_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(cfg_req.wr && cfg_req.addr == `PESL_OFS_SRC_ID && !unc_hit && !cor_hit) |=> $stable(src_id_r))
		else $error("source ids written by software");

	unit_apart_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		((pq_ovf || hot_plug_err != 4'h0) && !unc_hit && !cor_hit) |=> $stable(src_id_r))
		else $error("unit error reached the source ids");

	// Unit status bits
	unit_sticky_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(sys_rst && !pq_ovf && hot_plug_err == 4'h0 && !wr_unit) |=> $stable(unit_err_r))
		else $error("unit status lost on reset");

	hp_set_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(hot_plug_err != 4'h0) |=> ((unit_err_r[3:0] & $past(hot_plug_err)) == $past(hot_plug_err)))
		else $error("hot-plug bit not set");

	mid_zero_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		unit_err_r[14:4] == 11'h000)
		else $error("uncovered unit bit set");

	ovf_set_wins_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(wr_unit && cfg_req.wdata[15] && pq_ovf) |=> unit_err_r[15])
		else $error("clear beat a new overflow");

	hp_clear_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		(wr_unit && hot_plug_err == 4'h0) |=> ((unit_err_r[3:0] & $past(cfg_req.wdata[3:0])) == 4'h0))
		else $error("hot-plug bit not cleared");

	hp_keep_a: assert property (@(posedge clk_sys) disable iff (pwr_on_rst)
		!wr_unit |=> ((unit_err_r[3:0] & $past(unit_err_r[3:0])) == $past(unit_err_r[3:0])))
		else $error("hot-plug bit lost");

	// Reporting outputs
	rx_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!pq_ovf |=> !rx_overflow_evt)
		else $error("receiver overflow without overflow");

	ptr_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pq_ovf && !pq_ovf_report_mask_n) |=> unit_err_ptr_evt)
		else $error("pointer event missing");

	ptr_masked_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pq_ovf_report_mask_n |=> !unit_err_ptr_evt)
		else $error("pointer event while mask enabled");

	sel_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!sel_fatal && !sel_nonfatal)
		else $error("uncorrectable select raised");

	hp_route_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(hot_plug_err != 4'h0) |=> sel_correctable)
		else $error("hot-plug error not routed");

	cor_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(hot_plug_err == 4'h0) |=> !sel_correctable)
		else $error("correctable select without error");

	rst_quiet_a: assert property (@(posedge clk_sys)
		sys_rst |=> !rx_overflow_evt && !unit_err_ptr_evt && !sel_correctable && !cfg_rvalid)
		else $error("outputs not cleared by reset");

	// Configuration reads
	rd_src_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cfg_req.rd && cfg_req.addr == `PESL_OFS_SRC_ID) |=> cfg_rvalid && cfg_rdata == $past(src_id_r))
		else $error("source id read wrong");

	rd_unit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cfg_req.rd && cfg_req.addr == `PESL_OFS_UNIT_ERR) |=> cfg_rvalid && cfg_rdata == {16'h0000, $past(unit_err_r)})
		else $error("unit status read wrong");

	no_rd_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!cfg_req.rd |=> !cfg_rvalid && cfg_rdata == 32'h00000000)
		else $error("read data without read");
endmodule : pesl_top
